// ===== include/csw_pkg.sv
// Purpose: Shared constants and types for the position-mode status word builder.
// Assumes: One 20 MHz clock; inputs from the drive core are on the same clock unless said otherwise.
// Notes: Bit positions and state codes are named here once and used by name.
package csw_pkg;

  // ****************************************
  // Status word bit positions
  // ****************************************
  localparam int unsigned CSW_BIT_TORQUE = 15;
  localparam int unsigned CSW_BIT_FOLLOW = 13;
  localparam int unsigned CSW_BIT_TARGET = 12;
  localparam int unsigned CSW_BIT_LIMIT = 11;
  localparam int unsigned CSW_BIT_REMOTE = 9;
  localparam int unsigned CSW_BIT_WARN = 7;
  localparam int unsigned CSW_BIT_VOLT = 4;
  localparam int unsigned CSW_CTRL_HALT = 8;
  localparam logic [15:0] CSW_RESET_WORD = 16'h0000;
  // Top bit of the state code field; the field runs down to bit 0.
  localparam int unsigned CSW_STATE_MSB = 6;
  // Voltage bit as it sits inside the state code field.
  localparam logic [6:0] CSW_CODE_VOLT = 7'h10;
  // Bits 14, 10 and 8 carry nothing in this mode.
  localparam logic [15:0] CSW_UNUSED_MASK = 16'h4500;
  localparam logic [31:0] CSW_TARGET_RESET = 32'h00000000;

  // ****************************************
  // Alarm codes that release the following-error flag
  // ****************************************
  localparam logic [7:0] CSW_ALM_DEVIATION = 8'h10;
  localparam logic [7:0] CSW_ALM_OVERLOAD = 8'h30;

  // ****************************************
  // Drive state machine states, one-hot
  // ****************************************
  typedef enum logic [8:0] {
    CSW_ST_START = 9'h001,
    CSW_ST_NOT_READY = 9'h002,
    CSW_ST_FAULT = 9'h004,
    CSW_ST_FAULT_REACT = 9'h008,
    CSW_ST_SW_ON_DIS = 9'h010,
    CSW_ST_READY = 9'h020,
    CSW_ST_SWITCHED_ON = 9'h040,
    CSW_ST_OP_ENABLED = 9'h080,
    CSW_ST_QUICK_STOP = 9'h100
  } csw_state_t;

  // State codes for bits 6..0, voltage bit left at zero and filled later.
  localparam logic [6:0] CSW_CODE_OFF = 7'h00;
  localparam logic [6:0] CSW_CODE_FAULT = 7'h28;
  localparam logic [6:0] CSW_CODE_FAULT_REACT = 7'h2f;
  localparam logic [6:0] CSW_CODE_SW_ON_DIS = 7'h60;
  localparam logic [6:0] CSW_CODE_READY = 7'h21;
  localparam logic [6:0] CSW_CODE_SWITCHED_ON = 7'h23;
  localparam logic [6:0] CSW_CODE_OP_ENABLED = 7'h27;
  localparam logic [6:0] CSW_CODE_QUICK_STOP = 7'h07;

  // Limit sources gathered together.
  typedef struct packed {
    logic forward_limit_sensor;
    logic reverse_limit_sensor;
    logic forward_prohibit_input;
    logic reverse_prohibit_input;
    logic software_limit;
    logic mechanical_limit;
  } csw_limits_t;

  // Alarm clear event from the alarm logic.
  typedef struct packed {
    logic valid;
    logic [7:0] code;
  } csw_alarm_clr_t;

endpackage : csw_pkg

// ===== verilog/csw_status_word.sv
// Purpose: Builds the 16-bit drive status word for cyclic synchronous position mode.
// Assumes: Drive core signals share core_clk_in; the stop input is a pin and is filtered.
// Notes: The word and the target acceptance strobe are registered; one cycle of latency.
`timescale 1ns/100ps

// Operation
// - Bit 15 is high while output torque sits at its upper limit.
// - Bit 13 sets when position deviation exceeds the following-error window.
// - Bit 13 clears only when deviation alarm 10h or overload alarm 30h clears.
// - Bit 12 low, target ignored, if not enabled, unexcited, halt, stop or limit.
// - Otherwise bit 12 high and the commanded target position is accepted.
// - Bit 11 high while any limit sensor, prohibit input, software or mechanical limit.
// - Bit 9 is set once initialization has completed.
// - Bit 7 follows warning presence and clears by itself when causes vanish.
// - Bits 6..0 carry the drive state machine status output.
// - Bits 6..0 use the fixed code of each drive state.
// - Bit 4 shows main power presence in every state.
// - Control word bit 8 high requests an immediate stop.
module csw_status_word
  import csw_pkg::*;
(
  input wire logic core_clk_in, // 20 MHz core clock.
  input wire logic rst_b_in, // Asynchronous reset, active low.
  input wire csw_state_t drive_state_in, // Drive state machine state.
  input wire logic [15:0] control_word_in, // Control word from the master.
  input wire logic torque_limit_reached_in, // Torque at upper limit.
  input wire logic deviation_over_in, // Deviation beyond the window, level.
  input wire csw_alarm_clr_t alarm_clear_in, // Alarm clear event with its code.
  input wire logic motor_excited_in, // Motor is excited.
  input wire logic stop_pin_in, // Stop input pin, asynchronous.
  input wire csw_limits_t limits_in, // Internal limit sources.
  input wire logic init_done_in, // Initialization complete.
  input wire logic warning_present_in, // Any warning cause present.
  input wire logic main_power_in, // Main power present.
  input wire logic [31:0] target_pos_in, // Commanded target position.
  output logic [15:0] drive_status_word_out, // Status word.
  output logic [31:0] accepted_target_out, // Last accepted target position.
  output logic immediate_stop_out // Immediate stop request.
);

  // ****************************************
  // Helpers
  // ****************************************
  // Maps a drive state to its bits 6..0 code.
  function automatic logic [6:0] state_code(input csw_state_t st);
    logic [6:0] c;
    c = CSW_CODE_OFF;
    case (st)
      CSW_ST_FAULT: c = CSW_CODE_FAULT;
      CSW_ST_FAULT_REACT: c = CSW_CODE_FAULT_REACT;
      CSW_ST_SW_ON_DIS: c = CSW_CODE_SW_ON_DIS;
      CSW_ST_READY: c = CSW_CODE_READY;
      CSW_ST_SWITCHED_ON: c = CSW_CODE_SWITCHED_ON;
      CSW_ST_OP_ENABLED: c = CSW_CODE_OP_ENABLED;
      CSW_ST_QUICK_STOP: c = CSW_CODE_QUICK_STOP;
      default: c = CSW_CODE_OFF;
    endcase
    return c;
  endfunction : state_code

  // ****************************************
  // Stop pin filter
  // ****************************************
  logic stop_s1_q, stop_s2_q, stop_s3_q, stop_q;
  logic stop_d;

  // A change counts only once the second and third stages agree.
  always_comb begin
    stop_d = stop_q;
    if (stop_s2_q == stop_s3_q) begin
      stop_d = stop_s3_q;
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      stop_s1_q <= 1'b0;
      stop_s2_q <= 1'b0;
      stop_s3_q <= 1'b0;
      stop_q <= 1'b0;
    end else begin
      stop_s1_q <= stop_pin_in;
      stop_s2_q <= stop_s1_q;
      stop_s3_q <= stop_s2_q;
      stop_q <= stop_d;
    end
  end

  // ****************************************
  // Status word, sticky flag and target acceptance
  // ****************************************
  logic follow_q, follow_d;
  logic [15:0] word_q, word_d;
  logic [31:0] target_q, target_d;
  logic halt_q, halt_d;
  logic limit_any, target_ok, follow_release;

  // Following error is sticky; a new excursion beats a release in the same cycle.
  always_comb begin
    limit_any = |limits_in;
    halt_d = control_word_in[CSW_CTRL_HALT];
    follow_release = alarm_clear_in.valid &&
      (alarm_clear_in.code == CSW_ALM_DEVIATION || alarm_clear_in.code == CSW_ALM_OVERLOAD);
    follow_d = follow_q;
    if (deviation_over_in) begin
      follow_d = 1'b1;
    end else if (follow_release) begin
      follow_d = 1'b0;
    end
    // Halt is taken straight from the control word so no stale target slips through.
    target_ok = (drive_state_in == CSW_ST_OP_ENABLED) && motor_excited_in &&
      !control_word_in[CSW_CTRL_HALT] && !stop_q && !limit_any;
    target_d = target_ok ? target_pos_in : target_q;
    word_d = CSW_RESET_WORD;
    word_d[CSW_STATE_MSB:0] = state_code(drive_state_in);
    word_d[CSW_BIT_VOLT] = main_power_in;
    word_d[CSW_BIT_WARN] = warning_present_in;
    word_d[CSW_BIT_REMOTE] = init_done_in;
    word_d[CSW_BIT_LIMIT] = limit_any;
    word_d[CSW_BIT_TARGET] = target_ok;
    word_d[CSW_BIT_FOLLOW] = follow_d;
    word_d[CSW_BIT_TORQUE] = torque_limit_reached_in;
  end

  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      follow_q <= 1'b0;
      word_q <= CSW_RESET_WORD;
      target_q <= CSW_TARGET_RESET;
      halt_q <= 1'b0;
    end else begin
      follow_q <= follow_d;
      word_q <= word_d;
      target_q <= target_d;
      halt_q <= halt_d;
    end
  end

  assign drive_status_word_out = word_q;
  assign accepted_target_out = target_q;
  assign immediate_stop_out = halt_q;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rst_b_in);

  // Every check looks one edge after its cause, since the word is registered once.
  // The stop pin is the only input that takes longer: it needs two agreeing samples
  // and then two more edges before it reaches the target gate.
  sequence s_release;
    !deviation_over_in && follow_release;
  endsequence

  sequence s_stop_agreed;
    stop_s2_q == stop_s3_q;
  endsequence

  sequence s_stop_pin_on;
    stop_pin_in [*2];
  endsequence

  chk_torque_bit_follows: assert property (##1 drive_status_word_out[CSW_BIT_TORQUE] == $past(torque_limit_reached_in))
    else $error("Torque bit does not follow torque limit.");
  chk_follow_sets: assert property (deviation_over_in |=> drive_status_word_out[CSW_BIT_FOLLOW])
    else $error("Following error bit not set.");
  chk_follow_holds: assert property (follow_q && !follow_release |=> follow_q)
    else $error("Following error cleared without an alarm clear.");
  chk_follow_clears: assert property (s_release |=> !drive_status_word_out[CSW_BIT_FOLLOW])
    else $error("Following error not cleared by alarm clear.");
  chk_target_refused: assert property (drive_state_in != CSW_ST_OP_ENABLED || stop_q
    |=> !drive_status_word_out[CSW_BIT_TARGET] && accepted_target_out == $past(accepted_target_out))
    else $error("Target accepted while disabled.");
  chk_target_taken: assert property (target_ok |=> drive_status_word_out[CSW_BIT_TARGET]
    && accepted_target_out == $past(target_pos_in))
    else $error("Target not accepted while enabled.");
  chk_limit_bit: assert property (limit_any |=> drive_status_word_out[CSW_BIT_LIMIT]
    && !drive_status_word_out[CSW_BIT_TARGET])
    else $error("Limit bit or target gate wrong.");
  // A stuck-high limit bit would pass the check above, so the low side is watched too.
  chk_limit_clear: assert property (!limit_any |=> !drive_status_word_out[CSW_BIT_LIMIT])
    else $error("Limit bit set with no limit active.");
  chk_target_unexcited: assert property (!motor_excited_in |=> !drive_status_word_out[CSW_BIT_TARGET])
    else $error("Target accepted while motor unexcited.");
  chk_target_halt: assert property (control_word_in[CSW_CTRL_HALT]
    |=> !drive_status_word_out[CSW_BIT_TARGET] && accepted_target_out == $past(accepted_target_out))
    else $error("Target accepted during halt.");
  // The filter must pass a settled pin once the second and third stages agree.
  chk_stop_filter: assert property (s_stop_agreed |=> stop_q == $past(stop_s3_q))
    else $error("Stop filter output wrong.");
  chk_stop_reach: assert property (s_stop_pin_on |=> ##2 stop_q)
    else $error("Stop pin did not reach the target gate.");
  chk_remote_bit: assert property (##1 drive_status_word_out[CSW_BIT_REMOTE] == $past(init_done_in))
    else $error("Remote bit wrong.");
  chk_warn_bit: assert property (!warning_present_in |=> !drive_status_word_out[CSW_BIT_WARN])
    else $error("Warning bit not cleared.");
  chk_warn_set: assert property (warning_present_in |=> drive_status_word_out[CSW_BIT_WARN])
    else $error("Warning bit not set.");
  chk_state_code: assert property (drive_state_in == CSW_ST_OP_ENABLED && !main_power_in
    |=> drive_status_word_out[CSW_STATE_MSB:0] == CSW_CODE_OP_ENABLED)
    else $error("State code wrong.");
  // The voltage bit is masked here so these hold with main power on or off.
  chk_code_fault: assert property (drive_state_in == CSW_ST_FAULT
    |=> (drive_status_word_out[CSW_STATE_MSB:0] | CSW_CODE_VOLT) == (CSW_CODE_FAULT | CSW_CODE_VOLT))
    else $error("Fault state code wrong.");
  chk_code_sw_on_dis: assert property (drive_state_in == CSW_ST_SW_ON_DIS
    |=> (drive_status_word_out[CSW_STATE_MSB:0] | CSW_CODE_VOLT) == (CSW_CODE_SW_ON_DIS | CSW_CODE_VOLT))
    else $error("Switch-on-disabled state code wrong.");
  chk_code_quick_stop: assert property (drive_state_in == CSW_ST_QUICK_STOP
    |=> (drive_status_word_out[CSW_STATE_MSB:0] | CSW_CODE_VOLT) == (CSW_CODE_QUICK_STOP | CSW_CODE_VOLT))
    else $error("Quick stop state code wrong.");
  chk_volt_bit: assert property (main_power_in |=> drive_status_word_out[CSW_BIT_VOLT])
    else $error("Voltage bit wrong.");
  chk_volt_low: assert property (!main_power_in |=> !drive_status_word_out[CSW_BIT_VOLT])
    else $error("Voltage bit set without main power.");
  chk_halt_stop: assert property (control_word_in[CSW_CTRL_HALT] |=> immediate_stop_out)
    else $error("Halt not passed to stop.");
  chk_zero_bits: assert property ((drive_status_word_out & CSW_UNUSED_MASK) == CSW_RESET_WORD)
    else $error("Undefined bits not zero.");

endmodule : csw_status_word

// ===== bench/csw_master_model.sv
// Purpose: Fieldbus master stand-in that polls the status word every cycle.
// Assumes: Transmit process data arrives on every core clock edge.
// Notes: The poll adds one cycle to what the bench reads back.
`timescale 1ns/100ps
module csw_master_model (
  input wire logic core_clk_in, // Core clock.
  input wire logic rst_b_in, // Reset, active low.
  input wire logic [15:0] status_word_in, // Word sent as process data.
  output logic [15:0] polled_word_out // Last word taken in.
);
  // ****************************************
  // Cyclic poll
  // ****************************************
  // A copy per cycle, so a one-cycle glitch in the word still reaches polled_word_out.
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) polled_word_out <= 16'h0000;
    else polled_word_out <= status_word_in;
  end
endmodule : csw_master_model

// ===== bench/tb.sv
// Purpose: Self-checking bench for the status word builder.
// Assumes: Inputs change by non-blocking assignment on the rising edge.
// Notes: Words are read through the master model, two edges after a change.
`timescale 1ns/100ps
module tb;
  import csw_pkg::*;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  csw_state_t st = CSW_ST_START;
  logic [15:0] cw = 16'h0000;
  logic torq = 1'b0, dev = 1'b0, exc = 1'b0, stp = 1'b0, init = 1'b0, warn = 1'b0, pwr = 1'b0;
  csw_alarm_clr_t aclr = '0;
  csw_limits_t lim = '0;
  logic [31:0] tgt = 32'h0, acc;
  logic [15:0] sw, polled;
  logic istop;
  int n_errors = 0, compares = 0;
  csw_state_t sts [9] = '{CSW_ST_START, CSW_ST_NOT_READY, CSW_ST_FAULT, CSW_ST_FAULT_REACT,
    CSW_ST_SW_ON_DIS, CSW_ST_READY, CSW_ST_SWITCHED_ON, CSW_ST_OP_ENABLED, CSW_ST_QUICK_STOP};
  logic [6:0] codes [9] = '{7'h00, 7'h00, 7'h28, 7'h2f, 7'h60, 7'h21, 7'h23, 7'h27, 7'h07};
  logic [7:0] clr_codes [3] = '{8'h20, 8'h10, 8'h30};

  // ****************************************
  // Clock, design and partner
  // ****************************************
  // Free-running 20 MHz clock.
  initial begin
    forever #25 clk = ~clk;
  end
  csw_status_word dut_u (.core_clk_in(clk), .rst_b_in(rst_b), .drive_state_in(st), .control_word_in(cw),
    .torque_limit_reached_in(torq), .deviation_over_in(dev), .alarm_clear_in(aclr), .motor_excited_in(exc),
    .stop_pin_in(stp), .limits_in(lim), .init_done_in(init), .warning_present_in(warn), .main_power_in(pwr),
    .target_pos_in(tgt), .drive_status_word_out(sw), .accepted_target_out(acc), .immediate_stop_out(istop));
  csw_master_model master_u (.core_clk_in(clk), .rst_b_in(rst_b), .status_word_in(sw), .polled_word_out(polled));

  // ****************************************
  // Tasks
  // ****************************************
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // Called at a rising edge; returns at a rising edge so the caller may drive again.
  task automatic read_word(input logic [15:0] exp);
    repeat (2) @(posedge clk);
    @(negedge clk);
    check("status_word", {16'h0, polled}, {16'h0, exp});
    check("unused_bits", {29'h0, polled[14], polled[10], polled[8]}, 32'h0);
    @(posedge clk);
  endtask : read_word
  task automatic wrap_up;
    $display("Checks %0d, mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : wrap_up
  // Cuts a hang short.
  initial begin
    repeat (3000) @(posedge clk);
    n_errors++;
    $display("[ERR] timeout expected end seen hang");
    wrap_up();
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (10) @(posedge clk);
    check("reset_word", {16'h0, sw}, 32'h0);
    rst_b <= 1'b1;
    pwr <= 1'b1;
    for (int i = 0; i < 9; i++) begin
      st <= sts[i];
      read_word({9'h000, codes[i] | 7'h10});
    end
    pwr <= 1'b0;
    st <= CSW_ST_OP_ENABLED;
    read_word(16'h0027);
    $display("state codes done");
    pwr <= 1'b1;
    init <= 1'b1;
    exc <= 1'b1;
    for (int j = 0; j < 8; j++) begin
      torq <= (j == 0);
      warn <= (j == 1);
      lim <= (j >= 2) ? 6'(6'h20 >> (j - 2)) : 6'h00;
      tgt <= 32'(j);
      read_word(j == 0 ? 16'h9237 : j == 1 ? 16'h12b7 : 16'h0a37);
    end
    check("accepted", acc, 32'h1);
    lim <= '0;
    tgt <= 32'h0000_000a;
    read_word(16'h1237);
    check("accepted", acc, 32'h0000_000a);
    cw <= 16'h0100;
    tgt <= 32'h55;
    read_word(16'h0237);
    check("accepted", acc, 32'h0000_000a);
    check("stop_req", {31'h0, istop}, 32'h1);
    cw <= 16'h0000;
    exc <= 1'b0;
    stp <= 1'b1;
    read_word(16'h0237);
    check("stop_req", {31'h0, istop}, 32'h0);
    // The pin filter needs four edges; excite only once the stop has reached the gate.
    repeat (2) @(posedge clk);
    exc <= 1'b1;
    read_word(16'h0237);
    check("accepted", acc, 32'h0000_000a);
    stp <= 1'b0;
    repeat (5) @(posedge clk);
    read_word(16'h1237);
    check("accepted", acc, 32'h0000_0055);
    $display("target gating done");
    for (int k = 0; k < 3; k++) begin
      dev <= 1'b1;
      @(posedge clk);
      dev <= 1'b0;
      read_word(16'h3237);
      aclr <= '{valid: 1'b1, code: clr_codes[k]};
      @(posedge clk);
      aclr <= '0;
      read_word(k == 0 ? 16'h3237 : 16'h1237);
    end
    $display("following error done");
    wrap_up();
  end
endmodule : tb
